// ### core/mmpp_defines.svh
// Address map, widths and reset values of the parallel ports
//
// Functional notes
// [R1] Each port is a memory-mapped peripheral decoded at fixed offsets from its base.
// [R2] A port spans at most four 32-bit register words from its base.
// [R3] Output ports take writes at base; input ports return pin values on read.
// [R4] Bidirectional port has a direction register as wide as its data register.
// [R5] Direction bit 0 makes the data bit an input, 1 drives it out.
// [R6] Direction register sits at offset 4 from the port base.
// [R7] Offsets 8 and C are decoded; their function lies outside this block.
// [R8] Lamp port: 10-bit write-only data register at 0xFF200000 drives ten lamps.
// [R9] Lamp register written by words; bits above the ten are discarded.
// [R10] Two segment ports, each a 32-bit write-only register written by words.
// [R11] Segment register at 0xFF200020 drives digits three down to zero.
// [R12] Segment register at 0xFF200030 drives digits five and four.
// [R13] Segment bits drive display segments directly, no digit decoding.
// [R14] Switch port: 10-bit read-only register at 0xFF200040 returns switch positions.
// [R15] Reset clears output data and direction registers to zero.
`ifndef MMPP_DEFINES_SVH
`define MMPP_DEFINES_SVH

// ----------------------------------------
// Port base addresses and offsets
// ----------------------------------------
`define MMPP_LAMP_ADDR 32'hff200000
`define MMPP_LOW_SEG_ADDR 32'hff200020
`define MMPP_UP_SEG_ADDR 32'hff200030
`define MMPP_SLIDER_ADDR 32'hff200040
`define MMPP_GEN_BASE 32'hff200080
`define MMPP_DATA_OFS 32'h00000000
`define MMPP_DIR_OFS 32'h00000004
`define MMPP_SPARE8_OFS 32'h00000008
`define MMPP_SPAREC_OFS 32'h0000000c

// ----------------------------------------
// Widths, field positions, reset values
// ----------------------------------------
`define MMPP_REG_W 32
`define MMPP_LAMP_W 10
`define MMPP_SLIDER_W 10
`define MMPP_SEG_W 7
`define MMPP_DIGIT_STRIDE 8
`define MMPP_DATA_RST 32'h00000000
`define MMPP_DIR_RST 32'h00000000

`endif

// ### core/mmpp_pkg.sv
// Types shared by the parallel port modules
package mmpp_pkg;
`include "mmpp_defines.svh"

	// Register selected by a bus address
	typedef enum logic [2:0] {
		MMPP_SEL_NONE = 3'b000,
		MMPP_SEL_LAMP = 3'b001,
		MMPP_SEL_LOW_SEG = 3'b010,
		MMPP_SEL_UP_SEG = 3'b011,
		MMPP_SEL_SLIDER = 3'b100,
		MMPP_SEL_GEN_DATA = 3'b101,
		MMPP_SEL_GEN_DIR = 3'b110,
		MMPP_SEL_GEN_SPARE = 3'b111
	} mmpp_sel_e;

	// One bus request as seen in a single cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mmpp_req_s;

	// Full-word address compare; unaligned or foreign addresses select nothing
	function automatic mmpp_sel_e mmpp_decode(input logic [31:0] addr);
		mmpp_sel_e sel;
		sel = MMPP_SEL_NONE;
		if (addr == `MMPP_LAMP_ADDR) begin
			sel = MMPP_SEL_LAMP;
		end else if (addr == `MMPP_LOW_SEG_ADDR) begin
			sel = MMPP_SEL_LOW_SEG;
		end else if (addr == `MMPP_UP_SEG_ADDR) begin
			sel = MMPP_SEL_UP_SEG;
		end else if (addr == `MMPP_SLIDER_ADDR) begin
			sel = MMPP_SEL_SLIDER;
		end else if (addr == `MMPP_GEN_BASE + `MMPP_DATA_OFS) begin
			sel = MMPP_SEL_GEN_DATA;
		end else if (addr == `MMPP_GEN_BASE + `MMPP_DIR_OFS) begin
			sel = MMPP_SEL_GEN_DIR;
		end else if (addr == `MMPP_GEN_BASE + `MMPP_SPARE8_OFS ||
			addr == `MMPP_GEN_BASE + `MMPP_SPAREC_OFS) begin
			sel = MMPP_SEL_GEN_SPARE;
		end
		return sel;
	endfunction : mmpp_decode

endpackage : mmpp_pkg

// ### core/mmpp_out_reg.sv
// Write-only output data register of configurable width
`timescale 1ns/10ps
`include "mmpp_defines.svh"
module mmpp_out_reg
	import mmpp_pkg::*;
#(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Write strobe and word
	input wire logic i_we,
	input wire logic [31:0] i_wdata,
	// Register contents
	output logic [WIDTH-1:0] o_q
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (WIDTH < 1 || WIDTH > `MMPP_REG_W) begin : g_bad_width
		$error("mmpp_out_reg: WIDTH must be 1 to 32");
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Upper word bits beyond WIDTH are dropped by the part-select
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_q <= WIDTH'(`MMPP_DATA_RST); // [R15]
		end else if (i_we) begin
			o_q <= i_wdata[WIDTH-1:0]; // [R9]
		end
	end

endmodule : mmpp_out_reg

// ### core/mmpp_bidir_port.sv
// Bidirectional data and direction registers of one parallel port
`timescale 1ns/10ps
`include "mmpp_defines.svh"
module mmpp_bidir_port
	import mmpp_pkg::*;
#(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register writes
	input wire logic i_data_we,
	input wire logic i_dir_we,
	input wire logic [31:0] i_wdata,
	// Pins
	input wire logic [WIDTH-1:0] i_pin_in,
	output logic [WIDTH-1:0] o_pin_out,
	output logic [WIDTH-1:0] o_pin_oe,
	// Value seen when the data register is read
	output logic [WIDTH-1:0] o_rd_value
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (WIDTH < 1 || WIDTH > `MMPP_REG_W) begin : g_bad_width
		$error("mmpp_bidir_port: WIDTH must be 1 to 32");
	end

	// ----------------------------------------
	// Output data register
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pin_out <= WIDTH'(`MMPP_DATA_RST); // [R15]
		end else if (i_data_we) begin
			o_pin_out <= i_wdata[WIDTH-1:0]; // [R3]
		end
	end

	// ----------------------------------------
	// Direction register, one bit per data bit
	// ----------------------------------------
	// Reset leaves every bit an input so nothing fights the board at power-up
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pin_oe <= WIDTH'(`MMPP_DIR_RST); // [R15]
		end else if (i_dir_we) begin
			o_pin_oe <= i_wdata[WIDTH-1:0]; // [R4]
		end
	end

	// Inputs show the pin, outputs show what is being driven
	assign o_rd_value = (o_pin_oe & o_pin_out) | (~o_pin_oe & i_pin_in); // [R5]

endmodule : mmpp_bidir_port

// ### core/mmpp_top.sv
// Memory-mapped parallel ports: lamps, segment digits, switches, generic port
`timescale 1ns/10ps
`include "mmpp_defines.svh"
module mmpp_top
	import mmpp_pkg::*;
#(
	parameter int GEN_W = 32
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Processor word bus
	input wire logic [31:0] i_bus_addr,
	input wire logic i_bus_wr,
	input wire logic i_bus_rd,
	input wire logic [31:0] i_bus_wdata,
	output logic [31:0] o_bus_rdata,
	output logic o_bus_rvalid,
	// Lamps
	output logic [9:0] o_red_lamp_outputs,
	// Segment digits, bit 0 is segment 0
	output logic [6:0] o_digit_zero_segments,
	output logic [6:0] o_digit_one_segments,
	output logic [6:0] o_digit_two_segments,
	output logic [6:0] o_digit_three_segments,
	output logic [6:0] o_digit_four_segments,
	output logic [6:0] o_digit_five_segments,
	// Slider switches
	input wire logic [9:0] i_slider_inputs,
	// Generic bidirectional port pins
	input wire logic [GEN_W-1:0] i_gen_pin_in,
	output logic [GEN_W-1:0] o_gen_pin_out,
	output logic [GEN_W-1:0] o_gen_pin_oe
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (GEN_W < 1 || GEN_W > `MMPP_REG_W) begin : g_bad_gen_w
		$error("mmpp_top: GEN_W must be 1 to 32");
	end
	if (`MMPP_LAMP_W != 10 || `MMPP_SLIDER_W != 10) begin : g_bad_io_w
		$error("mmpp_top: lamp and switch widths must match the pins");
	end

	// ----------------------------------------
	// Request capture and decode
	// ----------------------------------------
	// The bus has no wait states: a request is taken on the edge where its
	// strobe is high, writes land on that edge and reads answer one cycle later.
	// Only exact word addresses select a register, so byte or halfword
	// addresses near a port fall through to the unmapped case.
	mmpp_req_s req;
	mmpp_sel_e sel;
	logic wr_lamp;
	logic wr_low_seg;
	logic wr_up_seg;
	logic wr_gen_data;
	logic wr_gen_dir;

	// Bundle the bus into one request word
	assign req.wr = i_bus_wr;
	assign req.rd = i_bus_rd;
	assign req.addr = i_bus_addr;
	assign req.wdata = i_bus_wdata;

	// Every register lives at a fixed offset from its port base
	assign sel = mmpp_decode(req.addr); // [R1] [R2]

	// Write strobes; a write to a read-only or spare word does nothing
	assign wr_lamp = req.wr && sel == MMPP_SEL_LAMP; // [R8]
	assign wr_low_seg = req.wr && sel == MMPP_SEL_LOW_SEG; // [R10] [R11]
	assign wr_up_seg = req.wr && sel == MMPP_SEL_UP_SEG; // [R10] [R12]
	assign wr_gen_data = req.wr && sel == MMPP_SEL_GEN_DATA; // [R3]
	assign wr_gen_dir = req.wr && sel == MMPP_SEL_GEN_DIR; // [R6]

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Segment words are stored whole; only seven bits of each byte lane are wired,
	// so the spare bit per lane and the upper half of the upper word cost a few
	// flip-flops but keep the write path the same for both segment ports.
	logic [31:0] low_seg_q;
	logic [31:0] up_seg_q;
	logic [GEN_W-1:0] gen_rd_value;

	// Lamp register keeps only the ten implemented bits
	mmpp_out_reg #(
		.WIDTH(`MMPP_LAMP_W)
	) u_lamp (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we(wr_lamp),
		.i_wdata(req.wdata),
		.o_q(o_red_lamp_outputs)
	); // [R9]

	// Digits three down to zero
	mmpp_out_reg #(
		.WIDTH(`MMPP_REG_W)
	) u_low_seg (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we(wr_low_seg),
		.i_wdata(req.wdata),
		.o_q(low_seg_q)
	);

	// Digits five and four; upper half of the word is stored but unwired
	mmpp_out_reg #(
		.WIDTH(`MMPP_REG_W)
	) u_up_seg (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_we(wr_up_seg),
		.i_wdata(req.wdata),
		.o_q(up_seg_q)
	);

	// Generic bidirectional port
	mmpp_bidir_port #(
		.WIDTH(GEN_W)
	) u_gen (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_data_we(wr_gen_data),
		.i_dir_we(wr_gen_dir),
		.i_wdata(req.wdata),
		.i_pin_in(i_gen_pin_in),
		.o_pin_out(o_gen_pin_out),
		.o_pin_oe(o_gen_pin_oe),
		.o_rd_value(gen_rd_value)
	);

	// ----------------------------------------
	// Segment fan-out
	// ----------------------------------------
	// Each digit owns one byte lane; bit 7 of each lane is unwired.
	// Segments are driven raw, so software builds its own glyphs.
	assign o_digit_zero_segments = low_seg_q[0*`MMPP_DIGIT_STRIDE +: `MMPP_SEG_W]; // [R13]
	assign o_digit_one_segments = low_seg_q[1*`MMPP_DIGIT_STRIDE +: `MMPP_SEG_W]; // [R11]
	assign o_digit_two_segments = low_seg_q[2*`MMPP_DIGIT_STRIDE +: `MMPP_SEG_W]; // [R11]
	assign o_digit_three_segments = low_seg_q[3*`MMPP_DIGIT_STRIDE +: `MMPP_SEG_W]; // [R11]
	assign o_digit_four_segments = up_seg_q[0*`MMPP_DIGIT_STRIDE +: `MMPP_SEG_W]; // [R12]
	assign o_digit_five_segments = up_seg_q[1*`MMPP_DIGIT_STRIDE +: `MMPP_SEG_W]; // [R12]

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [31:0] rd_mux;

	// Write-only, spare and unmapped words read as zero
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (sel)
			MMPP_SEL_SLIDER: rd_mux = 32'(i_slider_inputs); // [R14]
			MMPP_SEL_GEN_DATA: rd_mux = 32'(gen_rd_value); // [R3] [R5]
			MMPP_SEL_GEN_DIR: rd_mux = 32'(o_gen_pin_oe); // [R4]
			MMPP_SEL_GEN_SPARE: rd_mux = 32'h00000000; // [R7]
			MMPP_SEL_NONE,
			MMPP_SEL_LAMP,
			MMPP_SEL_LOW_SEG,
			MMPP_SEL_UP_SEG: rd_mux = 32'h00000000; // [R8] [R10]
		endcase
	end

	// Pins and switches are taken as synchronous, so the word seen on the
	// request edge goes straight into the read register with no extra stage.
	// Read data is captured in the request cycle and held until the next read
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_bus_rdata <= 32'h00000000;
		end else if (req.rd) begin
			o_bus_rdata <= rd_mux;
		end
	end

	// Answer strobe, one cycle after every read request
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_bus_rvalid <= 1'b0;
		end else begin
			o_bus_rvalid <= req.rd;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Checks are written against register and pin values rather than only the
	// internal strobes, so a wrong decode shows up as a wrong register value.
	// Reset disables every check; the reset check below overrides that on purpose.
	// Hold checks look two edges past the write, once the new value has settled.
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	// A read request followed by its answer
	sequence s_read_of(mmpp_sel_e s);
		req.rd && sel == s ##1 o_bus_rvalid;
	endsequence

	// A write followed by an idle bus cycle
	sequence s_write_then_idle(mmpp_sel_e s);
		req.wr && sel == s ##1 !req.wr;
	endsequence

	// A single write to the given register
	sequence s_write_of(mmpp_sel_e s);
		req.wr && sel == s;
	endsequence

	chk_lamp_load: assert property ( // [R8] [R9]
		wr_lamp |=> o_red_lamp_outputs == $past(req.wdata[9:0])
	) else $error("lamp register did not take the written low ten bits");

	chk_lamp_holds: assert property ( // [R8]
		s_write_then_idle(MMPP_SEL_LAMP) |=> $stable(o_red_lamp_outputs)
	) else $error("lamp register changed without a write");

	chk_low_digits: assert property ( // [R11] [R13]
		wr_low_seg |=> o_digit_zero_segments == $past(req.wdata[6:0]) &&
			o_digit_three_segments == $past(req.wdata[30:24])
	) else $error("lower digit segments differ from the written word");

	chk_up_digits: assert property ( // [R12] [R10]
		wr_up_seg |=> o_digit_four_segments == $past(req.wdata[6:0]) &&
			o_digit_five_segments == $past(req.wdata[14:8])
	) else $error("upper digit segments differ from the written word");

	chk_slider_read: assert property ( // [R14] [R3]
		req.rd && sel == MMPP_SEL_SLIDER |=>
			o_bus_rvalid && o_bus_rdata == {22'h000000, $past(i_slider_inputs)}
	) else $error("switch read returned a wrong value");

	chk_dir_offset: assert property ( // [R6] [R4]
		wr_gen_dir |=> o_gen_pin_oe == $past(req.wdata[GEN_W-1:0])
	) else $error("direction word at base plus four not stored");

	chk_pin_select: assert property ( // [R5]
		s_read_of(MMPP_SEL_GEN_DATA) |-> o_bus_rdata[GEN_W-1:0] ==
			(($past(o_gen_pin_oe) & $past(o_gen_pin_out)) |
			(~$past(o_gen_pin_oe) & $past(i_gen_pin_in)))
	) else $error("generic port read mixes pins and data wrongly");

	chk_wo_zero: assert property ( // [R2] [R7] [R1]
		req.rd && (sel == MMPP_SEL_LAMP || sel == MMPP_SEL_UP_SEG ||
			sel == MMPP_SEL_GEN_SPARE || sel == MMPP_SEL_NONE) |=>
			o_bus_rdata == 32'h00000000
	) else $error("write-only, spare or unmapped word read non-zero");

	chk_read_strobe: assert property ( // [R1]
		!req.rd |=> !o_bus_rvalid
	) else $error("read answer without a read request");

	chk_ro_write: assert property ( // [R14]
		req.wr && sel == MMPP_SEL_SLIDER |=>
			$stable(o_red_lamp_outputs) && $stable(o_gen_pin_oe)
	) else $error("write to the switch word disturbed another register");

	chk_reset_clear: assert property ( // [R15]
		@(posedge i_clk) disable iff (1'b0)
		i_rst |=> o_red_lamp_outputs == 10'h000 && o_gen_pin_oe == '0 &&
			o_gen_pin_out == '0 && o_digit_zero_segments == 7'h00 &&
			o_digit_five_segments == 7'h00 && !o_bus_rvalid
	) else $error("reset left an output register non-zero");

	// ----------------------------------------
	// Loads, holds and the read path
	// ----------------------------------------
	// Digits one and two sit in the middle byte lanes of the lower word
	chk_mid_digits: assert property ( // [R11] [R13]
		wr_low_seg |=> o_digit_one_segments == $past(req.wdata[14:8]) &&
			o_digit_two_segments == $past(req.wdata[22:16])
	) else $error("middle digit segments differ from the written word");

	// Generic data register takes the low bits of the written word
	chk_gen_load: assert property ( // [R3]
		s_write_of(MMPP_SEL_GEN_DATA) |=> o_gen_pin_out == $past(req.wdata[GEN_W-1:0])
	) else $error("generic data register not loaded from the written word");

	// Lower digits keep their pattern once the write is over
	chk_low_holds: assert property ( // [R11]
		s_write_then_idle(MMPP_SEL_LOW_SEG) |=> $stable(o_digit_zero_segments) &&
			$stable(o_digit_three_segments)
	) else $error("lower digit segments changed without a write");

	// Upper digits keep their pattern once the write is over
	chk_up_holds: assert property ( // [R12]
		s_write_then_idle(MMPP_SEL_UP_SEG) |=> $stable(o_digit_four_segments) &&
			$stable(o_digit_five_segments)
	) else $error("upper digit segments changed without a write");

	// Spare words are decoded but leave both port registers alone
	chk_spare_write: assert property ( // [R7]
		s_write_of(MMPP_SEL_GEN_SPARE) |=> $stable(o_gen_pin_oe) &&
			$stable(o_gen_pin_out)
	) else $error("write to a spare word changed the generic port");

	// Unmapped and unaligned writes land nowhere
	chk_stray_write: assert property ( // [R1] [R2]
		s_write_of(MMPP_SEL_NONE) |=> $stable(o_red_lamp_outputs) && $stable(low_seg_q) &&
			$stable(up_seg_q) && $stable(o_gen_pin_oe) && $stable(o_gen_pin_out)
	) else $error("write to an unmapped address changed a register");

	// Direction word reads back as stored
	chk_dir_read: assert property ( // [R4] [R6]
		s_read_of(MMPP_SEL_GEN_DIR) |-> o_bus_rdata[GEN_W-1:0] == $past(o_gen_pin_oe)
	) else $error("direction word read back differs from its register");

	// Lower segment word is write-only and reads as zero
	chk_seg_read_zero: assert property ( // [R10]
		s_read_of(MMPP_SEL_LOW_SEG) |-> o_bus_rdata == 32'h00000000
	) else $error("lower segment word read non-zero");

	// Every read request is answered on the next cycle
	chk_read_answer: assert property ( // [R1] [R3]
		req.rd |=> o_bus_rvalid
	) else $error("read request left without an answer");

	// Read data stands until the next read request
	chk_rdata_holds: assert property ( // [R3]
		!req.rd |=> $stable(o_bus_rdata)
	) else $error("read data changed without a read request");

	// Each register moves only on a write to its own word
	chk_lamp_only: assert property ( // [R8]
		!wr_lamp |=> $stable(o_red_lamp_outputs)
	) else $error("lamps changed without a lamp write");

	chk_low_only: assert property ( // [R11]
		!wr_low_seg |=> $stable(low_seg_q)
	) else $error("lower segment word changed without a write");

	chk_up_only: assert property ( // [R12]
		!wr_up_seg |=> $stable(up_seg_q)
	) else $error("upper segment word changed without a write");

	chk_data_only: assert property ( // [R3]
		!wr_gen_data |=> $stable(o_gen_pin_out)
	) else $error("generic data register changed without a write");

	chk_dir_only: assert property ( // [R6]
		!wr_gen_dir |=> $stable(o_gen_pin_oe)
	) else $error("direction word changed without a write to base plus four");

endmodule : mmpp_top

// ### test/mmpp_board_model.sv
// Board-side model: slider switches and the generic port's pins
`timescale 1ns/10ps
module mmpp_board_model
	import mmpp_pkg::*;
#(
	parameter int GEN_W = 32
) (
	// Stimulus from the bench
	input wire logic [9:0] i_switch_pos,
	input wire logic [GEN_W-1:0] i_ext_drive,
	// Device pin drive
	input wire logic [GEN_W-1:0] i_pin_out,
	input wire logic [GEN_W-1:0] i_pin_oe,
	// Levels seen by the device
	output logic [9:0] o_slider_inputs,
	output logic [GEN_W-1:0] o_pin_level
);
	// Switches are plain levels, no bounce modelled
	assign o_slider_inputs = i_switch_pos;
	// Wire level: the device wins where it drives, the board elsewhere
	assign o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_drive);
endmodule : mmpp_board_model

// ### test/memory_mapped_parallel_ports_tb.sv
// Self-checking bench for the memory-mapped parallel ports
`timescale 1ns/10ps
module memory_mapped_parallel_ports_tb
	import mmpp_pkg::*;
;
`include "mmpp_defines.svh"
	logic i_clk;
	logic i_rst;
	mmpp_req_s req;
	logic [31:0] rdata;
	logic rvalid;
	logic [9:0] lamps;
	logic [6:0] dg [6];
	logic [9:0] slide_pos;
	logic [9:0] slide_lvl;
	logic [31:0] ext;
	logic [31:0] pin_lvl;
	logic [31:0] pin_out;
	logic [31:0] pin_oe;
	logic [31:0] rd;
	int failures;
	int n_compared;

	mmpp_top mmpp_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_bus_addr(req.addr),
		.i_bus_wr(req.wr), .i_bus_rd(req.rd), .i_bus_wdata(req.wdata), .o_bus_rdata(rdata),
		.o_bus_rvalid(rvalid), .o_red_lamp_outputs(lamps), .o_digit_zero_segments(dg[0]),
		.o_digit_one_segments(dg[1]), .o_digit_two_segments(dg[2]),
		.o_digit_three_segments(dg[3]), .o_digit_four_segments(dg[4]),
		.o_digit_five_segments(dg[5]), .i_slider_inputs(slide_lvl), .i_gen_pin_in(pin_lvl),
		.o_gen_pin_out(pin_out), .o_gen_pin_oe(pin_oe));
	mmpp_board_model mmpp_board_model_inst (.i_switch_pos(slide_pos), .i_ext_drive(ext),
		.i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_slider_inputs(slide_lvl),
		.o_pin_level(pin_lvl));

	// Free-running 100 MHz clock
	always #5 i_clk = ~i_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Write is taken at the rising edge in the middle; strobe drops one cycle later
	task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
		@(negedge i_clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(negedge i_clk);
		req.wr = 1'b0;
	endtask : bus_write

	// Read data and valid stand for the cycle after the request edge
	task automatic bus_read(input logic [31:0] addr, output logic [31:0] data);
		@(negedge i_clk);
		req.rd = 1'b1;
		req.addr = addr;
		@(negedge i_clk);
		check("rvalid", {31'h0, rvalid}, 32'h1);
		data = rdata;
		req.rd = 1'b0;
	endtask : bus_read

	task automatic check_digits(input logic [6:0] exp [6]);
		for (int i = 0; i < 6; i++) begin
			check($sformatf("digit%0d", i), {25'h0, dg[i]}, {25'h0, exp[i]});
		end
	endtask : check_digits

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_state();
		check_digits('{7'h0, 7'h0, 7'h0, 7'h0, 7'h0, 7'h0});
		check("lamps", {22'h0, lamps}, 32'h0);
		check("pin_oe", pin_oe, 32'h0);
		check("pin_out", pin_out, 32'h0);
		bus_read(`MMPP_GEN_BASE + `MMPP_DIR_OFS, rd);
		check("dir after reset", rd, 32'h0);
	endtask : t_reset_state

	task automatic t_lamp();
		bus_write(`MMPP_LAMP_ADDR, 32'hfffffa5a);
		check("lamps", {22'h0, lamps}, 32'h25a);
		bus_read(`MMPP_LAMP_ADDR, rd);
		check("lamp readback", rd, 32'h0);
		// Unaligned address must not alias the lamp word
		bus_write(`MMPP_LAMP_ADDR + 32'h1, 32'h00000001);
		check("lamps unaligned", {22'h0, lamps}, 32'h25a);
	endtask : t_lamp

	task automatic t_segments();
		// Bit 7 set in lanes zero, one and three to show it is not wired
		bus_write(`MMPP_LOW_SEG_ADDR, 32'hff5abc81);
		check_digits('{7'h01, 7'h3c, 7'h5a, 7'h7f, 7'h0, 7'h0});
		bus_write(`MMPP_UP_SEG_ADDR, 32'h0000ad93);
		check_digits('{7'h01, 7'h3c, 7'h5a, 7'h7f, 7'h13, 7'h2d});
		bus_read(`MMPP_LOW_SEG_ADDR, rd);
		check("seg readback", rd, 32'h0);
	endtask : t_segments

	task automatic t_switches();
		slide_pos = 10'h2a5;
		bus_read(`MMPP_SLIDER_ADDR, rd);
		check("switches", rd, 32'h2a5);
		slide_pos = 10'h15a;
		bus_write(`MMPP_SLIDER_ADDR, 32'hffffffff);
		bus_read(`MMPP_SLIDER_ADDR, rd);
		check("switches after write", rd, 32'h15a);
	endtask : t_switches

	task automatic t_generic();
		bus_write(`MMPP_GEN_BASE + `MMPP_DIR_OFS, 32'h0000ffff);
		check("pin_oe", pin_oe, 32'h0000ffff);
		bus_write(`MMPP_GEN_BASE, 32'ha5a55a5a);
		check("pin_out", pin_out, 32'ha5a55a5a);
		ext = 32'h3c3cc3c3;
		bus_read(`MMPP_GEN_BASE, rd);
		check("gen data mixed", rd, 32'h3c3c5a5a);
		// Spare words are decoded but must not touch the direction word
		bus_write(`MMPP_GEN_BASE + `MMPP_SPARE8_OFS, 32'hffffffff);
		bus_read(`MMPP_GEN_BASE + `MMPP_DIR_OFS, rd);
		check("dir readback", rd, 32'h0000ffff);
		bus_read(`MMPP_GEN_BASE + `MMPP_SPAREC_OFS, rd);
		check("spare word", rd, 32'h0);
		bus_read(`MMPP_GEN_BASE + 32'h10, rd);
		check("beyond four words", rd, 32'h0);
	endtask : t_generic

	task automatic t_mid_reset();
		@(negedge i_clk);
		i_rst = 1'b1;
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		t_reset_state();
	endtask : t_mid_reset

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		req = '0;
		slide_pos = 10'h0;
		ext = 32'h0;
		failures = 0;
		n_compared = 0;
		repeat (10) @(negedge i_clk);
		i_rst = 1'b0;
		t_reset_state();
		t_lamp();
		t_segments();
		t_switches();
		t_generic();
		t_mid_reset();
		end_sim();
	end

	// Whole run needs well under 200 cycles
	initial begin
		#(2000 * 10);
		failures++;
		end_sim();
	end
endmodule : memory_mapped_parallel_ports_tb
